//--- prm_pkg.sv
// Shared constants for the registered lookup-array state machine.
// Assumes one clock domain; every configuration choice is a static parameter.
package prm_pkg;
	// ************************************************************
	// Array geometry
	// ************************************************************
	localparam int ADDR_W = 11;
	localparam int DATA_W = 16;
	localparam int DEPTH = 2048;
	// Array word bit that feeds back to address bit 0; bits 5..15 map to 0..10
	localparam int FB_LSB = 5;
	// ************************************************************
	// Pin reach per package variant
	// ************************************************************
	// Narrow variant: bits 7..0 reach pins, bits 15..8 are buried feedback
	localparam logic [15:0] PIN_MASK_NARROW = 16'h00ff;
	// Wide variant: every array word bit reaches a pin
	localparam logic [15:0] PIN_MASK_WIDE = 16'hffff;
	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [10:0] ADDR_RST = 11'h000;
	localparam logic BIT_RST = 1'b0;
endpackage

//--- prm_stage.sv
// One bank of bypassable capture registers.
// Assumes the common clock; the bypass mask is fixed before operation.
`timescale 1ns/1ps
`default_nettype none
module prm_stage
	import prm_pkg::*;
#(
	parameter int W = 1,
	parameter logic [W-1:0] BYPASS = '0,
	parameter logic [W-1:0] RST_VAL = '0
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q,
	output logic [W-1:0] y
);
	// Capture on every rising edge; the register is kept even when bypassed
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			q <= RST_VAL;
		end
		else
		begin
			q <= d;
		end
	end

	// Per-bit choice between captured and transparent path
	assign y = (d & BYPASS) | (q & ~BYPASS);
endmodule
`default_nettype wire

//--- prm_state_machine.sv
// Registered lookup-array state machine: 2048 x 16 array, address muxes,
// bypassable input, output, chip-select and initialize registers.
// Assumes inputs are produced on clk by surrounding board logic.
// How it works
// - A registered address input reaches the array one clock after the pin.
// - Each address register can be bypassed; cycle time does not change.
// - Output registers hold state and outputs; bypassed bits follow the array.
// - Eleven address bits, each muxed from its pin or from feedback.
// - Output enable gates the drivers with no clock involved.
// - Chip select has programmable polarity and two register stages.
// - Each chip-select stage can be bypassed on its own.
// - Initialize sampled low shows the init word after the next clock.
// - Initialize has its own bypassable input register.
// - Asynchronous initialize drives the init word onto bypassed outputs at once.
// - Initialize still loads bypassed output registers for feedback.
// - Narrow variant: bits 7..0 reach pins, 15..8 are buried feedback.
// - Wide variant: all sixteen bits reach pins, 15..5 also feed back.
// - Deselect floats the outputs, directly or on the capturing edge.
// - Each register either captures on the rising edge or is transparent.
// - All registers share the one common clock.
`timescale 1ns/1ps
`default_nettype none
module prm_state_machine
	import prm_pkg::*;
#(
	parameter bit WIDE_PINS = 1'b1,
	parameter logic [10:0] ADDR_BYPASS = 11'h000,
	parameter logic [10:0] FB_SELECT = 11'h000,
	parameter logic [15:0] OUT_BYPASS = 16'h0000,
	parameter logic [15:0] INIT_WORD = 16'h0000,
	parameter bit INIT_ASYNC = 1'b0,
	parameter bit INIT_BYPASS = 1'b0,
	parameter bit CS_ACTIVE_HIGH = 1'b0,
	parameter bit CS1_BYPASS = 1'b0,
	parameter bit CS2_BYPASS = 1'b0
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Machine inputs
	input wire logic [10:0] addr_pin,
	input wire logic init_n,
	input wire logic chip_sel,
	input wire logic out_en_n,
	// Array loading port
	input wire logic prog_we,
	input wire logic [10:0] prog_addr,
	input wire logic [15:0] prog_data,
	// Output pins as value and enable
	output logic [15:0] array_word_bits,
	output logic [15:0] array_word_oe
);
	// ************************************************************
	// Static configuration
	// ************************************************************
	// Pins that exist in the chosen package
	localparam logic [15:0] PIN_MASK = WIDE_PINS ? PIN_MASK_WIDE : PIN_MASK_NARROW;

	logic [15:0] mem [DEPTH];
	logic [10:0] addr_q;
	logic [10:0] addr_y;
	logic [10:0] fb_bits;
	logic [10:0] array_addr;
	logic [15:0] word;
	logic [15:0] next_state_word;
	logic [15:0] state_q;
	logic [15:0] drive_word;
	logic init_q;
	logic init_eff;
	logic cs_act;
	logic cs1_q;
	logic cs1_y;
	logic cs2_q;
	logic cs_en;

	// ************************************************************
	// Input side
	// ************************************************************
	// Address input registers, bypassable bit by bit
	prm_stage #(.W(ADDR_W), .BYPASS(ADDR_BYPASS), .RST_VAL(ADDR_RST)) u_addr_reg (
		.clk(clk),
		.srst(srst),
		.d(addr_pin),
		.q(addr_q),
		.y(addr_y)
	);

	// Initialize register, shares the common clock
	prm_stage #(.W(1), .BYPASS(INIT_BYPASS), .RST_VAL(BIT_RST)) u_init_reg (
		.clk(clk),
		.srst(srst),
		.d(~init_n),
		.q(init_q),
		.y(init_eff)
	);

	// Chip select polarity, then two cascaded stages
	assign cs_act = CS_ACTIVE_HIGH ? chip_sel : ~chip_sel;

	prm_stage #(.W(1), .BYPASS(CS1_BYPASS), .RST_VAL(BIT_RST)) u_cs1_reg (
		.clk(clk),
		.srst(srst),
		.d(cs_act),
		.q(cs1_q),
		.y(cs1_y)
	);

	prm_stage #(.W(1), .BYPASS(CS2_BYPASS), .RST_VAL(BIT_RST)) u_cs2_reg (
		.clk(clk),
		.srst(srst),
		.d(cs1_y),
		.q(cs2_q),
		.y(cs_en)
	);

	// ************************************************************
	// Address muxes and array
	// ************************************************************
	// Feedback always comes from the output registers, never the bypass path
	assign fb_bits = state_q[FB_LSB +: ADDR_W];
	assign array_addr = (fb_bits & FB_SELECT) | (addr_y & ~FB_SELECT);

	// Array storage in flops; loaded through the programming port
	always_ff @(posedge clk)
	begin
		if (prog_we)
		begin
			mem[prog_addr] <= prog_data;
		end
	end

	assign word = mem[array_addr];

	// ************************************************************
	// Output registers
	// ************************************************************
	// Initialize wins over the array word on the capturing edge
	assign next_state_word = init_eff ? INIT_WORD : word;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_q <= WORD_RST;
		end
		else
		begin
			state_q <= next_state_word;
		end
	end

	// Bypassed bits are Mealy outputs; async init overrides them at once
	always_comb
	begin
		drive_word = (word & OUT_BYPASS) | (state_q & ~OUT_BYPASS);
		if (INIT_ASYNC && init_eff)
		begin
			drive_word = (INIT_WORD & OUT_BYPASS) | (state_q & ~OUT_BYPASS);
		end
	end

	// Drivers: combinational so output enable acts without the clock
	// Trade-off: these outputs are not flops, by nature of the Mealy path
	always_comb
	begin
		array_word_bits = drive_word & PIN_MASK;
		array_word_oe = (!out_en_n && cs_en) ? PIN_MASK : 16'h0000;
	end

	// ************************************************************
	// Checks
	// ************************************************************
	localparam logic [10:0] PIN_REG_MASK = ~ADDR_BYPASS & ~FB_SELECT;
	localparam logic [10:0] PIN_BYP_MASK = ADDR_BYPASS & ~FB_SELECT;

	// Registered initialize: the captured request must steer the next load to the init word
	sequence s_init_taken;
		!init_n && !INIT_BYPASS;
	endsequence

	sequence s_init_ready;
		##1 (init_q && (next_state_word == INIT_WORD)) ##1 (state_q == INIT_WORD);
	endsequence

	a_addr_latency: assert property (
		@(posedge clk) disable iff (srst)
		!$past(srst) |-> ((array_addr & PIN_REG_MASK) == ($past(addr_pin) & PIN_REG_MASK)))
		else $error("Registered address bit not one cycle behind pin");

	a_addr_bypass: assert property (
		@(posedge clk) disable iff (srst)
		(array_addr & PIN_BYP_MASK) == (addr_pin & PIN_BYP_MASK))
		else $error("Bypassed address bit does not follow pin");

	a_fb_select: assert property (
		@(posedge clk) disable iff (srst)
		(array_addr & FB_SELECT) == (state_q[FB_LSB +: ADDR_W] & FB_SELECT))
		else $error("Feedback address bit not from output register");

	a_state_load: assert property (
		@(posedge clk) disable iff (srst)
		!$past(srst) && $past(init_eff) |-> (state_q == INIT_WORD))
		else $error("Initialize did not load output registers");

	a_mealy_out: assert property (
		@(posedge clk) disable iff (srst)
		!(INIT_ASYNC && init_eff) |-> ((drive_word & OUT_BYPASS) == (word & OUT_BYPASS)))
		else $error("Bypassed output does not follow array");

	a_oe_async: assert property (
		@(posedge clk) disable iff (srst)
		out_en_n |-> (array_word_oe == 16'h0000))
		else $error("Drivers on while output enable inactive");

	a_cs_two_stage: assert property (
		@(posedge clk) disable iff (srst)
		!CS1_BYPASS && !CS2_BYPASS && !$past(srst) && !$past(srst, 2)
		|-> (cs_en == $past(cs_act, 2)))
		else $error("Chip select not delayed by two stages");

	a_cs_deselect: assert property (
		@(posedge clk) disable iff (srst)
		!cs_en |-> (array_word_oe == 16'h0000))
		else $error("Outputs driven while deselected");

	a_init_sync: assert property (
		@(posedge clk) disable iff (srst)
		s_init_taken |-> s_init_ready)
		else $error("Init word not present two edges after sample");

	a_init_async: assert property (
		@(posedge clk) disable iff (srst)
		INIT_ASYNC && init_eff |-> ((drive_word & OUT_BYPASS) == (INIT_WORD & OUT_BYPASS)))
		else $error("Async init not on bypassed outputs");
endmodule
`default_nettype wire

//--- prm_board.sv
// Board-side pin model: resolves the device word and enables onto pins.
// Assumes the common clock; a released pin has no keeper or pull resistor.
`timescale 1ns/1ps
`default_nettype none
module prm_board
(
	// Clock
	input wire logic clk,
	// Device pins as value and enable
	input wire logic [15:0] bits,
	input wire logic [15:0] oe,
	// Level seen by the board
	output logic [15:0] pin_lvl
);
	logic [15:0] last;
	// Remember what each pin carried at the last edge
	always_ff @(posedge clk)
	begin
		last <= pin_lvl;
	end
	// A floating pin must not pass for a held value, so it shows the inverse
	always_comb
	begin
		pin_lvl = (bits & oe) | (~last & ~oe);
	end
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the lookup-array state machine.
// Assumes one 25 MHz clock and a board model that resolves the pins.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import prm_pkg::*;
	localparam logic [15:0] IW = 16'ha5c3;
	localparam logic [15:0] BYP = 16'h000f;
	// Address bit 1 bypassed; bit 10 fed back from word bit 15 opens a second page
	localparam logic [10:0] ABYP = 11'h002;
	localparam logic [10:0] FBS = 11'h400;
	// Page-zero words keep bit 15 clear; only the init word sets it
	localparam logic [15:0] MEM [5] = '{16'h3c96, 16'h5a0f, 16'h43e1, 16'h0ff0, 16'h1e78};
	localparam logic [10:0] PADDR [5] = '{11'h000, 11'h001, 11'h002, 11'h003, 11'h401};
	localparam int SEQ [6] = '{0, 1, 2, 3, 2, 1};
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [10:0] addr_pin = 11'h000;
	logic init_n = 1'b1;
	logic chip_sel = 1'b1;
	logic out_en_n = 1'b0;
	logic prog_we = 1'b0;
	logic [10:0] prog_addr = 11'h000;
	logic [15:0] prog_data = 16'h0000;
	logic [15:0] array_word_bits;
	logic [15:0] array_word_oe;
	logic [15:0] pin_lvl;
	logic [15:0] w;
	int ra;
	int ma;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	// Low nibble bypassed to show the combinational path beside the registered one
	// Initialize stays registered; async mode puts the word on the bypassed bits
	prm_state_machine #(.WIDE_PINS(1'b1), .ADDR_BYPASS(ABYP), .FB_SELECT(FBS),
		.OUT_BYPASS(BYP), .INIT_WORD(IW), .INIT_ASYNC(1'b1),
		.CS_ACTIVE_HIGH(1'b1), .CS1_BYPASS(1'b0), .CS2_BYPASS(1'b0))
	prm_state_machine_inst (.clk, .srst, .addr_pin, .init_n, .chip_sel, .out_en_n,
		.prog_we, .prog_addr, .prog_data, .array_word_bits, .array_word_oe);
	prm_board prm_board_inst (.clk, .bits(array_word_bits), .oe(array_word_oe), .pin_lvl);
	always #20 clk = ~clk;
	// Cut a hang short well past the thirty or so cycles the tests need
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			errors++;
			tally_and_finish();
		end
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Waits n edges and lets the last one's updates land before looking
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic tally_and_finish();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		// Load the array under reset so fed-back state never carries an unknown
		for (int i = 0; i < 5; i++)
		begin
			@(posedge clk);
			prog_we <= 1'b1;
			prog_addr <= PADDR[i];
			prog_data <= MEM[i];
		end
		@(posedge clk);
		prog_we <= 1'b0;
		srst <= 1'b0;
		// Back-to-back addresses: bit 0 is registered, bit 1 reaches the array at once
		for (int n = 0; n < 6; n++)
		begin
			@(posedge clk);
			addr_pin <= 11'(SEQ[n]);
			#1;
			if (n >= 2)
			begin
				ra = (SEQ[n-1] & 2) | (SEQ[n-2] & 1);
				ma = (SEQ[n] & 2) | (SEQ[n-1] & 1);
				chk("reg bits", array_word_bits & ~BYP, MEM[ra] & ~BYP);
				chk("mealy bits", array_word_bits & BYP, MEM[ma] & BYP);
			end
		end
		tick(3);
		// Initialize pulse of one cycle: word appears after the following edge
		@(posedge clk);
		init_n <= 1'b0;
		@(posedge clk);
		init_n <= 1'b1;
		#1;
		chk("init early", array_word_bits & ~BYP, MEM[1] & ~BYP);
		chk("async init", array_word_bits & BYP, IW & BYP);
		tick(1);
		chk("init word", array_word_bits & ~BYP, IW & ~BYP);
		tick(1);
		// Bit 15 of the init word feeds back and selects the second page
		chk("init page", array_word_bits & ~BYP, MEM[4] & ~BYP);
		// Deselect travels through both chip-select stages
		@(posedge clk);
		chip_sel <= 1'b0;
		#1;
		chk("cs edge0", array_word_oe, 16'hffff);
		tick(1);
		chk("cs edge1", array_word_oe, 16'hffff);
		tick(1);
		chk("cs edge2", array_word_oe, 16'h0000);
		@(posedge clk);
		chip_sel <= 1'b1;
		tick(2);
		chk("cs back", array_word_oe, 16'hffff);
		// Output enable acts without waiting for a clock edge
		w = pin_lvl;
		@(posedge clk);
		out_en_n <= 1'b1;
		#1;
		chk("oe off", array_word_oe, 16'h0000);
		chk("float pins", pin_lvl, ~w);
		@(posedge clk);
		out_en_n <= 1'b0;
		#1;
		chk("oe on", array_word_oe, 16'hffff);
		tally_and_finish();
	end
endmodule
`default_nettype wire
